// ===== core/crs_pkg.sv
// constants, types and field layouts of the core register set
// assumes a single machine clock and an active-high asynchronous reset
package crs_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int CRS_DW = 16;                        // register width
  localparam int CRS_AW = 8;                         // register port address width

  // ***************************************************************
  // register port offsets
  // ***************************************************************
  localparam logic [7:0] CRS_OFS_IP     = 8'h00;    // instruction pointer
  localparam logic [7:0] CRS_OFS_ACC    = 8'h01;    // primary working register
  localparam logic [7:0] CRS_OFS_TMP    = 8'h02;    // secondary working register
  localparam logic [7:0] CRS_OFS_IDX    = 8'h03;    // index register
  localparam logic [7:0] CRS_OFS_EXT    = 8'h04;    // extra pointer
  localparam logic [7:0] CRS_OFS_SP     = 8'h05;    // stack pointer
  localparam logic [7:0] CRS_OFS_PSW    = 8'h06;    // program status word
  localparam logic [7:0] CRS_OFS_MIRROR = 8'h78;    // bank and window pointer mirror

  // ***************************************************************
  // status word field positions
  // ***************************************************************
  localparam int CRS_PSW_BANK_LSB = 11;              // bank select pointer, 5 bits
  localparam int CRS_PSW_WIN_LSB  = 8;               // direct window bits, 3 bits
  localparam int CRS_FLG_H      = 7;                 // half carry
  localparam int CRS_FLG_I      = 6;                 // interrupt enable
  localparam int CRS_FLG_IL_LSB = 4;                 // current irq level, 2 bits
  localparam int CRS_FLG_N      = 3;                 // negative
  localparam int CRS_FLG_Z      = 2;                 // zero
  localparam int CRS_FLG_V      = 1;                 // overflow
  localparam int CRS_FLG_C      = 0;                 // carry

  // ***************************************************************
  // reset values and address constants
  // ***************************************************************
  localparam logic [15:0] CRS_RST_REG  = 16'h0000;  // pointers and working registers
  localparam logic [15:0] CRS_RST_PSW  = 16'h0030;  // window 0, irq off, level 3
  localparam logic [15:0] CRS_GPR_BASE = 16'h0100;  // first register bank
  localparam int          CRS_WIN_LSB  = 7;          // 128-byte window size

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    CRS_OP_ADD  = 3'b000,
    CRS_OP_SUB  = 3'b001,
    CRS_OP_SHL  = 3'b010,
    CRS_OP_SHR  = 3'b011,
    CRS_OP_PASS = 3'b100
  } crs_alu_op_t;

  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } crs_flags_t;

  typedef struct packed {
    logic [15:0] res;                                // result
    crs_flags_t  flg;                                // produced flags
    crs_flags_t  upd;                                // which flags are written
  } crs_alu_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } crs_bus_t;

  typedef struct packed {
    logic        en;                                 // write strobe
    logic [7:0]  sel;                                // target, same codes as port offsets
    logic [15:0] data;
    logic        w8;                                 // byte operation: low byte only for acc and tmp targets; other targets take the whole word
  } crs_core_wr_t;

endpackage : crs_pkg

// ===== core/crs_core_regs.sv
// dedicated register set of the cpu core with flag unit, window remap,
// bank register addressing and interrupt gate
// assumes the decoder and alu drive their strobes from the same clock
//
// Overview of operation
// - sixteen-bit instruction pointer for fetch address
// - sixteen-bit accumulator; byte ops touch low byte
// - sixteen-bit second operand; byte ops use low byte
// - index, extra and stack pointer registers
// - status word: pointers high byte, flags low
// - three-bit window pointer remaps 80h-FFh upward
// - direct addresses below 80h never remapped
// - only direct-mode accesses are remapped
// - half carry from bit three into four
// - interrupt enable flag, cleared at reset
// - request accepted only above current level
// - negative flag copies result msb
// - zero flag marks zero result
// - overflow flag marks signed overflow
// - carry flag marks carry out of msb
// - shifts put shifted-out bit into carry
// - bank registers live in memory, 32 banks
// - bank pointer plus opcode bits pick register
// - sixteen-bit addresses span 64 Kbyte space
// - pointers mirrored at an i/o location
module crs_core_regs (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // register port
  input  wire crs_pkg::crs_bus_t    bus_i,
  output logic [15:0]               rdata_o,
  // decoder write port and instruction pointer step
  input  wire crs_pkg::crs_core_wr_t core_wr_i,
  input  wire logic                 ip_step_i,
  // arithmetic unit
  input  wire logic                 alu_go_i,
  input  wire crs_pkg::crs_alu_op_t alu_op_i,
  input  wire logic                 alu_w8_i,
  // address generation
  input  wire logic                 dir_mode_i,
  input  wire logic [15:0]          addr_i,
  input  wire logic [2:0]           reg_idx_i,
  output logic [15:0]               mem_addr_o,
  output logic [15:0]               gpr_addr_o,
  // interrupt gate
  input  wire logic                 irq_req_i,
  input  wire logic [1:0]           irq_level_i,
  output logic                      irq_accept_o,
  // register contents
  output logic [15:0]               instr_pointer_o,
  output logic [15:0]               acc_o,
  output logic [15:0]               temp_o,
  output logic [15:0]               index_reg_o,
  output logic [15:0]               extra_pointer_o,
  output logic [15:0]               stack_pointer_reg_o,
  output logic [15:0]               program_status_word_o
);

  // ***************************************************************
  // functions
  // ***************************************************************

  // keeps the high byte of a byte-wide write
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv, input logic w8);
    merge = w8 ? {old[15:8], nv[7:0]} : nv;
  endfunction

  // computes result and flags for one operation
  function automatic crs_pkg::crs_alu_t alu_calc(input crs_pkg::crs_alu_op_t op, input logic [15:0] a,
                                                 input logic [15:0] b, input logic w8);
    logic [16:0]       ea;
    logic [16:0]       eb;
    logic [16:0]       s;
    logic [4:0]        hs;
    logic              ma;
    logic              mb;
    logic              ms;
    crs_pkg::crs_alu_t o;
    ea = w8 ? {9'h000, a[7:0]} : {1'b0, a};
    eb = w8 ? {9'h000, b[7:0]} : {1'b0, b};
    s  = ea;
    hs = 5'h00;
    o  = '0;
    case (op)
      crs_pkg::CRS_OP_ADD: begin
        s     = ea + eb;
        hs    = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        o.upd = 5'h1f;
      end
      crs_pkg::CRS_OP_SUB: begin
        s     = ea - eb;
        hs    = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        o.upd = 5'h1f;
      end
      crs_pkg::CRS_OP_SHL: begin
        s     = {ea[15:0], 1'b0};
        o.upd = 5'h0d;
      end
      crs_pkg::CRS_OP_SHR: begin
        s     = {1'b0, ea[16:1]};
        o.upd = 5'h0d;
      end
      crs_pkg::CRS_OP_PASS: begin
        s     = ea;
        o.upd = 5'h0c;
      end
      default: begin
        s     = ea;
        o.upd = 5'h00;
      end
    endcase
    ma      = w8 ? a[7] : a[15];
    mb      = w8 ? b[7] : b[15];
    ms      = w8 ? s[7] : s[15];
    o.res   = s[15:0];
    o.flg.h = hs[4];
    o.flg.n = ms;
    o.flg.z = w8 ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
    // carry out of the msb, or the bit pushed out by a shift
    o.flg.c = (op == crs_pkg::CRS_OP_SHR) ? a[0] : (w8 ? s[8] : s[16]);
    // signed overflow for add and subtract only
    if (op == crs_pkg::CRS_OP_ADD) begin
      o.flg.v = (ma == mb) && (ms != ma);
    end else if (op == crs_pkg::CRS_OP_SUB) begin
      o.flg.v = (ma != mb) && (ms != ma);
    end else begin
      o.flg.v = 1'b0;
    end
    return o;
  endfunction

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [15:0] ip_r,  ip_nxt;                       // instruction pointer
  logic [15:0] acc_r, acc_nxt;                      // primary working register
  logic [15:0] tmp_r, tmp_nxt;                      // secondary working register
  logic [15:0] idx_r, idx_nxt;                      // index register
  logic [15:0] ext_r, ext_nxt;                      // extra pointer
  logic [15:0] sp_r,  sp_nxt;                       // stack pointer
  logic [15:0] psw_r, psw_nxt;                      // program status word
  logic [15:0] rdata_r, rdata_nxt;                  // read data, one cycle after strobe
  logic [15:0] mem_addr_r;                          // registered physical address
  logic [15:0] gpr_addr_r;                          // registered bank register address

  // ***************************************************************
  // decode
  // ***************************************************************
  wire logic              bw     = bus_i.wr;                          // port write strobe
  wire logic              cw     = core_wr_i.en;                      // decoder write strobe
  wire logic              bw_ip  = bw && (bus_i.addr == crs_pkg::CRS_OFS_IP);
  wire logic              bw_acc = bw && (bus_i.addr == crs_pkg::CRS_OFS_ACC);
  wire logic              bw_tmp = bw && (bus_i.addr == crs_pkg::CRS_OFS_TMP);
  wire logic              bw_idx = bw && (bus_i.addr == crs_pkg::CRS_OFS_IDX);
  wire logic              bw_ext = bw && (bus_i.addr == crs_pkg::CRS_OFS_EXT);
  wire logic              bw_sp  = bw && (bus_i.addr == crs_pkg::CRS_OFS_SP);
  wire logic              bw_psw = bw && (bus_i.addr == crs_pkg::CRS_OFS_PSW);
  wire logic              bw_mir = bw && (bus_i.addr == crs_pkg::CRS_OFS_MIRROR);
  wire logic              cw_ip  = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_IP);
  wire logic              cw_acc = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_ACC);
  wire logic              cw_tmp = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_TMP);
  wire logic              cw_idx = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_IDX);
  wire logic              cw_ext = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_EXT);
  wire logic              cw_sp  = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_SP);
  wire logic              cw_psw = cw && (core_wr_i.sel == crs_pkg::CRS_OFS_PSW);
  wire logic [15:0]       cdat   = core_wr_i.data;
  wire logic              cw8    = core_wr_i.w8;

  // status word fields
  wire logic [4:0]        bank_ptr = psw_r[crs_pkg::CRS_PSW_BANK_LSB +: 5];
  wire logic [2:0]        win_ptr  = psw_r[crs_pkg::CRS_PSW_WIN_LSB +: 3];
  wire logic              flag_i = psw_r[crs_pkg::CRS_FLG_I];
  wire logic [1:0]        il     = psw_r[crs_pkg::CRS_FLG_IL_LSB +: 2];

  // arithmetic on the two working registers
  wire crs_pkg::crs_alu_t alu    = alu_calc(alu_op_i, acc_r, tmp_r, alu_w8_i);

  // ***************************************************************
  // next-state selection: alu over decoder over port
  // ***************************************************************

  // instruction pointer: load, else step to the next fetch byte
  assign ip_nxt  = cw_ip ? cdat : bw_ip ? bus_i.wdata : ip_step_i ? ip_r + 16'h0001 : ip_r;
  // accumulator keeps its high byte on byte-wide results
  assign acc_nxt = alu_go_i ? merge(acc_r, alu.res, alu_w8_i) :
                   cw_acc   ? merge(acc_r, cdat, cw8) :
                   bw_acc   ? bus_i.wdata : acc_r;
  assign tmp_nxt = cw_tmp ? merge(tmp_r, cdat, cw8) : bw_tmp ? bus_i.wdata : tmp_r;
  assign idx_nxt = cw_idx ? cdat : bw_idx ? bus_i.wdata : idx_r;
  assign ext_nxt = cw_ext ? cdat : bw_ext ? bus_i.wdata : ext_r;
  assign sp_nxt  = cw_sp  ? cdat : bw_sp  ? bus_i.wdata : sp_r;

  // status word: writes first, then the alu overrides only the flags it updates
  logic [15:0] psw_base;
  assign psw_base = cw_psw ? cdat :
                    bw_psw ? bus_i.wdata :
                    bw_mir ? {bus_i.wdata[7:0], psw_r[7:0]} : psw_r;

  always_comb begin
    psw_nxt = psw_base;
    // fixed flag positions in the low byte
    if (alu_go_i) begin
      if (alu.upd.h) psw_nxt[crs_pkg::CRS_FLG_H] = alu.flg.h;
      if (alu.upd.n) psw_nxt[crs_pkg::CRS_FLG_N] = alu.flg.n;
      if (alu.upd.z) psw_nxt[crs_pkg::CRS_FLG_Z] = alu.flg.z;
      if (alu.upd.v) psw_nxt[crs_pkg::CRS_FLG_V] = alu.flg.v;
      if (alu.upd.c) psw_nxt[crs_pkg::CRS_FLG_C] = alu.flg.c;
    end
  end

  // ***************************************************************
  // address generation
  // ***************************************************************

  // direct addresses 80h-FFh land in window (window+1)*80h; window 0 gives 80h itself
  wire logic [3:0]  win     = {1'b0, win_ptr} + 4'h1;
  wire logic        remap   = dir_mode_i && addr_i[crs_pkg::CRS_WIN_LSB];
  wire logic [15:0] dir_adr = {5'h00, win, addr_i[6:0]};
  wire logic [15:0] phys    = remap ? dir_adr : addr_i;
  // bank register: base + 8 * bank + index from the opcode
  wire logic [15:0] gpr     = crs_pkg::CRS_GPR_BASE + {8'h00, bank_ptr, reg_idx_i};

  // ***************************************************************
  // read mux
  // ***************************************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    // unmapped offsets read zero
    case (bus_i.addr)
      crs_pkg::CRS_OFS_IP:     rdata_nxt = ip_r;
      crs_pkg::CRS_OFS_ACC:    rdata_nxt = acc_r;
      crs_pkg::CRS_OFS_TMP:    rdata_nxt = tmp_r;
      crs_pkg::CRS_OFS_IDX:    rdata_nxt = idx_r;
      crs_pkg::CRS_OFS_EXT:    rdata_nxt = ext_r;
      crs_pkg::CRS_OFS_SP:     rdata_nxt = sp_r;
      crs_pkg::CRS_OFS_PSW:    rdata_nxt = psw_r;
      crs_pkg::CRS_OFS_MIRROR: rdata_nxt = {8'h00, psw_r[15:8]};
      default:                 rdata_nxt = 16'h0000;
    endcase
    if (!bus_i.rd) begin
      rdata_nxt = 16'h0000;
    end
  end

  // ***************************************************************
  // state flops
  // ***************************************************************

  // working and pointer registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ip_r  <= crs_pkg::CRS_RST_REG;
      acc_r <= crs_pkg::CRS_RST_REG;
      tmp_r <= crs_pkg::CRS_RST_REG;
      idx_r <= crs_pkg::CRS_RST_REG;
      ext_r <= crs_pkg::CRS_RST_REG;
      sp_r  <= crs_pkg::CRS_RST_REG;
    end else begin
      ip_r  <= ip_nxt;
      acc_r <= acc_nxt;
      tmp_r <= tmp_nxt;
      idx_r <= idx_nxt;
      ext_r <= ext_nxt;
      sp_r  <= sp_nxt;
    end
  end

  // status word: window 0, interrupts off after reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      psw_r <= crs_pkg::CRS_RST_PSW;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // port read data and registered addresses
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r    <= 16'h0000;
      mem_addr_r <= 16'h0000;
      gpr_addr_r <= crs_pkg::CRS_GPR_BASE;
    end else begin
      rdata_r    <= rdata_nxt;
      mem_addr_r <= phys;
      gpr_addr_r <= gpr;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // a lower level number is a higher priority; a level-3 request is never taken
  assign irq_accept_o          = irq_req_i && flag_i && (irq_level_i < il);
  assign rdata_o               = rdata_r;
  assign mem_addr_o            = mem_addr_r;
  assign gpr_addr_o            = gpr_addr_r;
  assign instr_pointer_o       = ip_r;
  assign acc_o                 = acc_r;
  assign temp_o                = tmp_r;
  assign index_reg_o           = idx_r;
  assign extra_pointer_o       = ext_r;
  assign stack_pointer_reg_o   = sp_r;
  assign program_status_word_o = psw_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // port read of the instruction pointer
  sequence s_rd_ip;
    bus_i.rd && (bus_i.addr == crs_pkg::CRS_OFS_IP);
  endsequence
  // byte-wide alu operation
  sequence s_alu8;
    alu_go_i && alu_w8_i;
  endsequence

  property p_rd_ip;
    s_rd_ip |=> (rdata_o == $past(ip_r));
  endproperty
  a_rd_ip: assert property (p_rd_ip) else $error("ip read data wrong");

  property p_ip_step;
    ip_step_i && !cw_ip && !bw_ip |=> (instr_pointer_o == $past(ip_r) + 16'h0001);
  endproperty
  a_ip_step: assert property (p_ip_step) else $error("ip did not step");

  property p_acc_hi;
    s_alu8 |=> (acc_o[15:8] == $past(acc_r[15:8]));
  endproperty
  a_acc_hi: assert property (p_acc_hi) else $error("byte op changed acc high byte");

  property p_zero;
    (s_alu8 and alu.upd.z) |=> (psw_r[crs_pkg::CRS_FLG_Z] == (acc_o[7:0] == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_neg;
    (s_alu8 and alu.upd.n) |=> (psw_r[crs_pkg::CRS_FLG_N] == acc_o[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_shl_c;
    (s_alu8 and (alu_op_i == crs_pkg::CRS_OP_SHL)) |=> (psw_r[crs_pkg::CRS_FLG_C] == $past(acc_r[7]));
  endproperty
  a_shl_c: assert property (p_shl_c) else $error("shift carry wrong");

  property p_low_direct;
    !addr_i[7] |=> (mem_addr_o == $past(addr_i));
  endproperty
  a_low_direct: assert property (p_low_direct) else $error("low direct address remapped");

  property p_window;
    dir_mode_i && addr_i[7] && (win_ptr == 3'h7) |=> (mem_addr_o == {9'h008, $past(addr_i[6:0])});
  endproperty
  a_window: assert property (p_window) else $error("window 7 not at 400h");

  property p_gpr;
    1'b1 |=> (gpr_addr_o == 16'h0100 + 16'($past(bank_ptr)) * 16'h0008 + 16'($past(reg_idx_i)));
  endproperty
  a_gpr: assert property (p_gpr) else $error("bank register address wrong");

  property p_irq_lvl3;
    (irq_level_i == 2'h3) |-> !irq_accept_o;
  endproperty
  a_irq_lvl3: assert property (p_irq_lvl3) else $error("level 3 let an irq through");

  property p_mirror;
    bw_mir && !cw_psw |=> (psw_r[15:8] == $past(bus_i.wdata[7:0]));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror write lost");

endmodule // crs_core_regs

// ===== sim/crs_decoder_model.sv
// decoder and alu strobe model facing the core register set
// assumes the bench calls its tasks from one process
module crs_decoder_model (
  // clock
  input  wire logic             clock,
  // strobes toward the register set
  output crs_pkg::crs_core_wr_t core_wr_o,
  output logic                  ip_step_o,
  output logic                  alu_go_o,
  output crs_pkg::crs_alu_op_t  alu_op_o,
  output logic                  alu_w8_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle strobes from time zero
  initial begin
    core_wr_o = '0;
    ip_step_o = 1'b0;
    alu_go_o  = 1'b0;
    alu_op_o  = crs_pkg::CRS_OP_ADD;
    alu_w8_o  = 1'b0;
  end
  // one-cycle decoder write, byte or word
  task automatic wr(input logic [7:0] s, input logic [15:0] d, input logic w);
    @(posedge clock);
    core_wr_o <= '{en: 1'b1, sel: s, data: d, w8: w};
    @(posedge clock);
    core_wr_o.en <= 1'b0;
    #1;
  endtask
  // one-cycle alu run on acc and temp
  task automatic alu(input crs_pkg::crs_alu_op_t op, input logic w);
    @(posedge clock);
    alu_go_o <= 1'b1;
    alu_op_o <= op;
    alu_w8_o <= w;
    @(posedge clock);
    alu_go_o <= 1'b0;
    #1;
  endtask
  // one instruction pointer step
  task automatic step();
    @(posedge clock);
    ip_step_o <= 1'b1;
    @(posedge clock);
    ip_step_o <= 1'b0;
    #1;
  endtask
endmodule // crs_decoder_model

// ===== sim/crs_core_regs_bench.sv
// self-checking bench of the core register set
// assumes crs_pkg and crs_decoder_model are compiled first
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, x); end end
module crs_core_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, ip_step, alu_go, alu_w8, dir_mode, irq_req, irq_acc, w, dm;
  crs_pkg::crs_bus_t     bus;
  crs_pkg::crs_core_wr_t cw;
  crs_pkg::crs_alu_op_t  alu_op;
  logic [15:0] rdata, mem_addr, gpr_addr, ip, acc, tmp, idx, ext, sp, psw, addr, a, b, v, ev, ad;
  logic [2:0]  ridx, win;
  logic [4:0]  bank;
  logic [1:0]  lvl;
  logic [31:0] e;
  int num_errors, checked, cycles, seed, i, j;
  crs_decoder_model crs_decoder_model_inst (.clock(clock), .core_wr_o(cw), .ip_step_o(ip_step),
    .alu_go_o(alu_go), .alu_op_o(alu_op), .alu_w8_o(alu_w8));
  crs_core_regs crs_core_regs_inst (.clock(clock), .reset(reset), .bus_i(bus), .rdata_o(rdata),
    .core_wr_i(cw), .ip_step_i(ip_step), .alu_go_i(alu_go), .alu_op_i(alu_op), .alu_w8_i(alu_w8),
    .dir_mode_i(dir_mode), .addr_i(addr), .reg_idx_i(ridx), .mem_addr_o(mem_addr), .gpr_addr_o(gpr_addr),
    .irq_req_i(irq_req), .irq_level_i(lvl), .irq_accept_o(irq_acc), .instr_pointer_o(ip), .acc_o(acc),
    .temp_o(tmp), .index_reg_o(idx), .extra_pointer_o(ext), .stack_pointer_reg_o(sp),
    .program_status_word_o(psw));
  // 250 MHz clock and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // register port write and read, data taken the cycle after rd
  task automatic bw(input logic [7:0] a8, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a8, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a8, output logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a8, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // expected acc and status word after one alu run
  function automatic logic [31:0] exp_alu(input int op, input logic [15:0] a, b, p, input logic w8);
    logic [16:0] r;
    logic [15:0] x, y;
    logic c, vf, h;
    int m;
    m = w8 ? 7 : 15;
    x = w8 ? {8'h00, a[7:0]} : a;
    y = w8 ? {8'h00, b[7:0]} : b;
    case (op)
      0: begin r = x + y; c = r[m+1]; h = ({1'b0, x[3:0]} + y[3:0]) > 5'h0f;
        vf = (x[m] == y[m]) && (r[m] != x[m]); end
      1: begin r = x - y; c = x < y; h = x[3:0] < y[3:0]; vf = (x[m] != y[m]) && (r[m] != x[m]); end
      2: begin r = {1'b0, x << 1}; c = x[m]; end
      3: begin r = {1'b0, x >> 1}; c = x[0]; end
      default: begin r = {1'b0, x}; c = p[crs_pkg::CRS_FLG_C]; end
    endcase
    p[crs_pkg::CRS_FLG_N] = r[m];
    p[crs_pkg::CRS_FLG_Z] = w8 ? (r[7:0] == 8'h00) : (r[15:0] == 16'h0000);
    p[crs_pkg::CRS_FLG_C] = c;
    if (op < 2) begin
      p[crs_pkg::CRS_FLG_V] = vf;
      p[crs_pkg::CRS_FLG_H] = h;
    end
    return {w8 ? {a[15:8], r[7:0]} : r[15:0], p};
  endfunction
  // closing report
  task automatic tally_and_finish();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    seed = 55179;
    reset = 1'b1;
    bus = '0;
    {dir_mode, irq_req, addr, ridx, lvl} = '0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 9; i++) begin
      br(i == 7 ? 8'h78 : (i == 8 ? 8'h10 : i[7:0]), v);
      `CHK(v, i == 6 ? crs_pkg::CRS_RST_PSW : 16'h0000)
    end
    `CHK(gpr_addr, 16'h0100)
    $display("reset values done");
    for (i = 0; i < 7; i++) begin
      v = i < 6 ? $random(seed) : 16'hffff;
      bw(i < 6 ? i[7:0] : 8'h20, v);
      br(i < 6 ? i[7:0] : 8'h20, ev);
      `CHK(ev, i < 6 ? v : 16'h0000)
      if (i < 6) `CHK(16'({ip, acc, tmp, idx, ext, sp} >> (16 * (5 - i))), ev)
    end
    bw(8'h00, 16'hffff);
    crs_decoder_model_inst.step();
    `CHK(ip, 16'h0000)
    bw(8'h01, 16'habcd);
    crs_decoder_model_inst.wr(8'h01, 16'h1234, 1'b1);
    `CHK(acc, 16'hab34)
    $display("register access done");
    ev = crs_pkg::CRS_RST_PSW;
    for (i = 0; i < 48; i++) begin
      a = $random(seed);
      b = $random(seed);
      j = i < 4 ? i : {$random(seed)} % 5;
      w = i < 4 ? 1'b0 : $random(seed);
      if (i == 0) {a, b} = {16'h7fff, 16'h0001};
      if (i == 1) {a, b} = {16'h0000, 16'h0001};
      if (i > 1 && i < 4) a = i == 2 ? 16'h8000 : 16'h0001;
      bw(8'h01, a);
      bw(8'h02, b);
      crs_decoder_model_inst.alu(crs_pkg::crs_alu_op_t'(j[2:0]), w);
      e = exp_alu(j, a, b, ev, w);
      `CHK(acc, e[31:16])
      `CHK(psw, e[15:0])
      ev = e[15:0];
    end
    $display("flag unit done");
    for (i = 0; i < 40; i++) begin
      {bank, win} = $random(seed);
      dm = $random(seed);
      ad = $random(seed);
      if (i == 0) {bank, win, dm, ad} = {5'h1f, 3'h7, 1'b1, 16'h00ff};
      if (dm) ad[15:8] = 8'h00;
      bw(8'h78, {8'h00, bank, win});
      br(8'h78, v);
      `CHK(v, {8'h00, bank, win})
      `CHK(psw[15:8], {bank, win})
      @(posedge clock);
      {dir_mode, addr, ridx} <= {dm, ad, ad[2:0] ^ win};
      @(posedge clock);
      #1 `CHK(mem_addr, dm && ad[7] ? ((16'(win) + 16'h0001) << 7) | {9'h000, ad[6:0]} : ad)
      `CHK(gpr_addr, 16'h0100 + {8'h00, bank, 3'b000} + 16'(ad[2:0] ^ win))
    end
    $display("address paths done");
    for (i = 0; i < 64; i++) begin
      bw(8'h06, {8'h00, 1'b0, i[4], i[3:2], 4'h0});
      @(posedge clock);
      {irq_req, lvl} <= {i[5], i[1:0]};
      #1 `CHK(irq_acc, i[5] & i[4] & (i[1:0] < i[3:2]))
    end
    $display("interrupt gate done");
    tally_and_finish();
  end
endmodule // crs_core_regs_bench
